/* File: design/accel_timing_pkg.sv */
// constants, field layouts and decoders for the timing and measurement registers
// How it works
// - rate field bits 7:5 picks 400, 800, 1600, 3200 or 6400 Hz sampling.
// - bit 1 selects the outside sample clock, bit 0 the outside trigger; both reset zero.
// - doze interval field bits 4:2 picks 52 ms up to 24576 ms between measurements.
// - autosleep bit 6 drops the device into doze once stillness is detected.
// - autosleep is ignored unless chaining is linked or looped.
// - chaining 0 runs enabled detectors together and disables autosleep.
// - linked chaining arms exactly one detector at a time, in turn.
// - looped chaining sequences like linked and acknowledges flags internally.
// - linked or looped fall back to default unless both detector enables are set.
// - measurement bit 3 selects low noise operation.
// - bandwidth bits 2:0 set the four-pole filter corner, 200 to 3200 Hz.
package accel_timing_pkg;

   localparam logic [7:0] TIMING_ADDR = 8'h3d;
   localparam logic [7:0] MEASUREMENT_SETTINGS_ADDR = 8'h3e;
   localparam logic [7:0] TIMING_RESET = 8'h00;
   localparam logic [7:0] MEASUREMENT_SETTINGS_RESET = 8'h00;

   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;

   localparam logic [1:0] CHAIN_DEFAULT = 2'h0;
   localparam logic [1:0] CHAIN_LINKED = 2'h1;
   localparam logic [1:0] CHAIN_LOOPED = 2'h2;

   localparam logic [2:0] RATE_LAST_CODE = 3'h4;
   localparam logic [2:0] BW_HOLE_CODE = 3'h2;
   localparam logic [2:0] BW_LAST_CODE = 3'h4;

   typedef struct packed {
      logic [2:0] output_rate_sel;
      logic [2:0] doze_interval_sel;
      logic outside_clock_en;
      logic outside_trigger_en;
   } timing_type;

   typedef struct packed {
      logic overrange_off;
      logic autosleep;
      logic [1:0] detector_chain_mode;
      logic low_noise;
      logic [2:0] bandwidth_sel;
   } measurement_settings_type;

   typedef enum logic [1:0] {
      WATCH_MOTION = 2'b01,
      WATCH_STILL = 2'b10
   } chain_state_type;

   // sample rate in Hz per rate code; undefined codes give zero
   function automatic int rate_hz(input logic [2:0] code);
      unique case (code)
         3'h0: rate_hz = 400;
         3'h1: rate_hz = 800;
         3'h2: rate_hz = 1600;
         3'h3: rate_hz = 3200;
         3'h4: rate_hz = 6400;
         default: rate_hz = 0;
      endcase
   endfunction

   // doze interval in ms per code
   function automatic logic [14:0] doze_ms(input logic [2:0] code);
      unique case (code)
         3'h0: doze_ms = 15'd52;
         3'h1: doze_ms = 15'd104;
         3'h2: doze_ms = 15'd208;
         3'h3: doze_ms = 15'd512;
         3'h4: doze_ms = 15'd2048;
         3'h5: doze_ms = 15'd4096;
         3'h6: doze_ms = 15'd8192;
         default: doze_ms = 15'd24576;
      endcase
   endfunction

endpackage

/* File: design/tick_gen.sv */
// free running divider giving a one-cycle tick every i_period cycles
`timescale 1ns/1ps
module tick_gen
   import accel_timing_pkg::*;
#(
   parameter int WIDTH = 20
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_reset, // synchronous reset
   input wire logic i_run, // counting allowed
   input wire logic [WIDTH-1:0] i_period, // cycles per tick, at least 1
   output logic o_tick // one-cycle tick
);
   logic [WIDTH-1:0] count_q, count_d;
   logic tick_d;

   always_comb begin
      count_d = count_q;
      tick_d = 1'b0;
      if (!i_run) begin
         count_d = '0;
      end else if (count_q >= i_period - WIDTH'(1)) begin
         count_d = '0;
         tick_d = 1'b1;
      end else begin
         count_d = count_q + WIDTH'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         count_q <= '0;
         o_tick <= 1'b0;
      end else begin
         count_q <= count_d;
         o_tick <= tick_d;
      end
   end
endmodule // tick_gen

/* File: design/accel_timing_measurement_settings_ctrl.sv */
// timing and measurement settings with detector chaining and doze timer
`timescale 1ns/1ps
module accel_timing_measurement_settings_ctrl
   import accel_timing_pkg::*;
#(
   parameter int CLOCK_HZ = CLK_HZ
) (
   input wire logic i_core_clk, // 40 MHz core clock
   input wire logic i_reset, // synchronous, active high
   input wire logic i_reg_wr, // register write strobe
   input wire logic [7:0] i_reg_addr, // register address
   input wire logic [7:0] i_reg_wdata, // write data
   output logic [7:0] o_reg_rdata, // read data, one cycle after address
   input wire logic i_motion_detect_en, // motion detector enable
   input wire logic i_stillness_detect_en, // stillness detector enable
   input wire logic i_motion_event, // motion over threshold
   input wire logic i_stillness_event, // stillness detected
   input wire logic i_status_read, // host read of status
   input wire logic i_wake_mode, // host selected doze mode
   input wire logic i_outside_clock_tick, // sample tick from outside clock
   input wire logic i_outside_trigger, // outside sample trigger
   output logic o_sample_tick, // take a sample
   output logic o_wake_measurement_settings, // doze interval elapsed
   output logic o_doze_active, // autosleep doze
   output logic o_motion_armed, // motion detector running
   output logic o_stillness_armed, // stillness detector running
   output logic o_motion_flag, // motion pending
   output logic o_stillness_flag, // stillness pending
   output logic o_outside_clock_en, // outside clock selected
   output logic o_outside_trigger_en, // outside trigger selected
   output logic o_low_noise, // low noise operation
   output logic o_overrange_off, // overrange disable
   output logic [2:0] o_bandwidth_sel, // filter corner code
   output logic o_rate_code_valid, // rate code is defined
   output logic o_bw_code_valid // bandwidth code is defined
);
   localparam int PW = 24;
   localparam logic [PW-1:0] MS_CYCLES = PW'(CLOCK_HZ / MS_PER_S);

   timing_type timing_q, timing_d;
   measurement_settings_type measurement_settings_q, measurement_settings_d;
   chain_state_type state_q, state_d;
   logic [7:0] rdata_d;
   logic motion_armed_d, still_armed_d, motion_flag_d, still_flag_d;
   logic doze_d, sample_d, wake_d;
   logic [14:0] ms_cnt_q, ms_cnt_d;
   logic chain_eff, looped_eff, auto_eff, rate_ok;
   logic motion_set, still_set, flag_clr_m, flag_clr_s;
   logic base_tick, ms_tick, doze_run;
   logic [PW-1:0] rate_period;

   // registers
   always_comb begin
      timing_d = timing_q;
      measurement_settings_d = measurement_settings_q;
      if (i_reg_wr && i_reg_addr == TIMING_ADDR) begin
         timing_d = timing_type'(i_reg_wdata);
      end
      if (i_reg_wr && i_reg_addr == MEASUREMENT_SETTINGS_ADDR) begin
         measurement_settings_d = measurement_settings_type'(i_reg_wdata);
      end
      unique case (i_reg_addr)
         TIMING_ADDR: rdata_d = timing_q;
         MEASUREMENT_SETTINGS_ADDR: rdata_d = measurement_settings_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         timing_q <= timing_type'(TIMING_RESET);
         measurement_settings_q <= measurement_settings_type'(MEASUREMENT_SETTINGS_RESET);
         o_reg_rdata <= 8'h00;
      end else begin
         timing_q <= timing_d;
         measurement_settings_q <= measurement_settings_d;
         o_reg_rdata <= rdata_d;
      end
   end

   assign o_outside_clock_en = timing_q.outside_clock_en;
   assign o_outside_trigger_en = timing_q.outside_trigger_en;
   assign o_low_noise = measurement_settings_q.low_noise;
   assign o_overrange_off = measurement_settings_q.overrange_off;
   assign o_bandwidth_sel = measurement_settings_q.bandwidth_sel;

   // sample timing
   // undefined rate codes stop the internal timer instead of guessing a rate
   assign rate_ok = timing_q.output_rate_sel <= RATE_LAST_CODE;
   assign rate_period = rate_ok ? PW'(CLOCK_HZ / rate_hz(timing_q.output_rate_sel))
                                : PW'(1);

   tick_gen #(.WIDTH(PW)) u_rate_tick (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_run(rate_ok && !timing_q.outside_clock_en),
      .i_period(rate_period),
      .o_tick(base_tick)
   );

   tick_gen #(.WIDTH(PW)) u_ms_tick (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_run(doze_run),
      .i_period(MS_CYCLES),
      .o_tick(ms_tick)
   );

   // detector chaining
   always_comb begin
      chain_eff = (measurement_settings_q.detector_chain_mode == CHAIN_LINKED
                   || measurement_settings_q.detector_chain_mode == CHAIN_LOOPED)
                  && i_motion_detect_en && i_stillness_detect_en;
      looped_eff = chain_eff && measurement_settings_q.detector_chain_mode == CHAIN_LOOPED;
      auto_eff = chain_eff && measurement_settings_q.autosleep;
      motion_set = i_motion_event && o_motion_armed;
      still_set = i_stillness_event && o_stillness_armed;
      // looped chaining acks a flag itself one cycle after it rose
      flag_clr_m = looped_eff ? o_motion_flag : i_status_read;
      flag_clr_s = looped_eff ? o_stillness_flag : i_status_read;
      state_d = state_q;
      if (!chain_eff) begin
         state_d = WATCH_MOTION;
         motion_armed_d = i_motion_detect_en;
         still_armed_d = i_stillness_detect_en;
      end else begin
         unique case (state_q)
            WATCH_MOTION: if (motion_set) state_d = WATCH_STILL;
            WATCH_STILL: if (still_set) state_d = WATCH_MOTION;
            default: state_d = WATCH_MOTION;
         endcase
         motion_armed_d = state_d == WATCH_MOTION;
         still_armed_d = state_d == WATCH_STILL;
      end
      // a new event beats the clear in the same cycle
      motion_flag_d = motion_set || (o_motion_flag && !flag_clr_m);
      still_flag_d = still_set || (o_stillness_flag && !flag_clr_s);
      doze_d = o_doze_active;
      if (!auto_eff || motion_set) begin
         doze_d = 1'b0;
      end else if (still_set) begin
         doze_d = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_q <= WATCH_MOTION;
         o_motion_armed <= 1'b0;
         o_stillness_armed <= 1'b0;
         o_motion_flag <= 1'b0;
         o_stillness_flag <= 1'b0;
         o_doze_active <= 1'b0;
      end else begin
         state_q <= state_d;
         o_motion_armed <= motion_armed_d;
         o_stillness_armed <= still_armed_d;
         o_motion_flag <= motion_flag_d;
         o_stillness_flag <= still_flag_d;
         o_doze_active <= doze_d;
      end
   end

   // doze timer and sample output
   assign doze_run = o_doze_active || i_wake_mode;

   always_comb begin
      ms_cnt_d = ms_cnt_q;
      wake_d = 1'b0;
      if (!doze_run) begin
         ms_cnt_d = '0;
      end else if (ms_tick) begin
         if (ms_cnt_q >= doze_ms(timing_q.doze_interval_sel) - 15'd1) begin
            ms_cnt_d = '0;
            wake_d = 1'b1;
         end else begin
            ms_cnt_d = ms_cnt_q + 15'd1;
         end
      end
      sample_d = timing_q.outside_clock_en ? i_outside_clock_tick : base_tick;
      if (timing_q.outside_trigger_en) begin
         sample_d = i_outside_trigger;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ms_cnt_q <= '0;
         o_wake_measurement_settings <= 1'b0;
         o_sample_tick <= 1'b0;
         o_rate_code_valid <= 1'b1;
         o_bw_code_valid <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_d;
         o_wake_measurement_settings <= wake_d;
         o_sample_tick <= sample_d;
         o_rate_code_valid <= rate_ok;
         o_bw_code_valid <= measurement_settings_q.bandwidth_sel != BW_HOLE_CODE
                            && measurement_settings_q.bandwidth_sel <= BW_LAST_CODE;
      end
   end

   // checks
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   property p_timing_store;
      i_reg_wr && i_reg_addr == TIMING_ADDR |=> timing_q == $past(i_reg_wdata) ##1
         (o_reg_rdata == $past(i_reg_wdata, 2) || $past(i_reg_addr) != TIMING_ADDR);
   endproperty
   a_timing_store: assert property (p_timing_store) else $error("timing write lost");

   property p_outside_clock_en_bit;
      i_reg_wr && i_reg_addr == TIMING_ADDR |=> o_outside_clock_en == $past(i_reg_wdata[1])
         && o_outside_trigger_en == $past(i_reg_wdata[0]);
   endproperty
   a_outside_clock_en_bit: assert property (p_outside_clock_en_bit) else $error("outside enables wrong");

   property p_one_armed;
      chain_eff && $past(chain_eff) |-> o_motion_armed != o_stillness_armed;
   endproperty
   a_one_armed: assert property (p_one_armed) else $error("chain armed both or none");

   property p_default_armed;
      !chain_eff |=> o_motion_armed == $past(i_motion_detect_en)
         && o_stillness_armed == $past(i_stillness_detect_en);
   endproperty
   a_default_armed: assert property (p_default_armed) else $error("default arming wrong");

   property p_loop_ack;
      looped_eff && o_motion_flag && !motion_set |=> !o_motion_flag;
   endproperty
   a_loop_ack: assert property (p_loop_ack) else $error("looped flag not acked");

   property p_host_ack;
      !looped_eff && o_stillness_flag && !i_status_read |=> o_stillness_flag;
   endproperty
   a_host_ack: assert property (p_host_ack) else $error("flag dropped without read");

   property p_doze_cause;
      $rose(o_doze_active) |-> $past(auto_eff) && $past(still_set);
   endproperty
   a_doze_cause: assert property (p_doze_cause) else $error("doze without autosleep");

   property p_doze_entry;
      auto_eff && still_set && !motion_set |=> o_doze_active;
   endproperty
   a_doze_entry: assert property (p_doze_entry) else $error("autosleep missed");

   property p_interval_bound;
      doze_run |-> ms_cnt_q < doze_ms(timing_q.doze_interval_sel)
         || $changed(timing_q.doze_interval_sel) || $past(timing_q.doze_interval_sel)
            != timing_q.doze_interval_sel || ms_cnt_q == $past(ms_cnt_q);
   endproperty
   a_interval_bound: assert property (p_interval_bound) else $error("doze count overrun");

   property p_low_noise;
      i_reg_wr && i_reg_addr == MEASUREMENT_SETTINGS_ADDR |=> ##1 o_low_noise == $past(i_reg_wdata[3], 2)
         || $past(i_reg_wr && i_reg_addr == MEASUREMENT_SETTINGS_ADDR);
   endproperty
   a_low_noise: assert property (p_low_noise) else $error("low noise bit wrong");

   property p_measurement_settings_store;
      i_reg_wr && i_reg_addr == MEASUREMENT_SETTINGS_ADDR |=> o_bandwidth_sel == $past(i_reg_wdata[2:0])
         && o_overrange_off == $past(i_reg_wdata[7]);
   endproperty
   a_measurement_settings_store: assert property (p_measurement_settings_store) else $error("measurement_settings write lost");

   property p_unmapped_read;
      i_reg_addr != TIMING_ADDR && i_reg_addr != MEASUREMENT_SETTINGS_ADDR |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_chain_swap;
      chain_eff && motion_set |=> o_stillness_armed && !o_motion_armed;
   endproperty
   a_chain_swap: assert property (p_chain_swap) else $error("motion hit did not swap");

   property p_still_swap;
      chain_eff && still_set && !motion_set |=> o_motion_armed && !o_stillness_armed;
   endproperty
   a_still_swap: assert property (p_still_swap) else $error("stillness hit did not swap");

   property p_doze_exit;
      !auto_eff || motion_set |=> !o_doze_active;
   endproperty
   a_doze_exit: assert property (p_doze_exit) else $error("doze held wrongly");

   property p_trigger_pass;
      timing_q.outside_trigger_en |=> o_sample_tick == $past(i_outside_trigger);
   endproperty
   a_trigger_pass: assert property (p_trigger_pass) else $error("trigger not passed");

   // one settled cycle needed: the divider tick is itself registered
   property p_rate_stop;
      !rate_ok && $past(!rate_ok) && !timing_q.outside_clock_en
         && !timing_q.outside_trigger_en |=> !o_sample_tick;
   endproperty
   a_rate_stop: assert property (p_rate_stop) else $error("sample on undefined rate");

   property p_wake_gap;
      o_wake_measurement_settings |=> !o_wake_measurement_settings;
   endproperty
   a_wake_gap: assert property (p_wake_gap) else $error("wake pulse too long");

endmodule // accel_timing_measurement_settings_ctrl

/* File: bench/accel_host_model.sv */
// host model driving the register strobe bus and status reads
`timescale 1ns/1ps
module accel_host_model (
   input wire logic i_core_clk, // core clock
   input wire logic [7:0] i_reg_rdata, // read data from device
   output logic o_reg_wr, // write strobe
   output logic [7:0] o_reg_addr, // register address
   output logic [7:0] o_reg_wdata, // write data
   output logic o_status_read // status read pulse
);
   initial begin
      o_reg_wr = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
      o_status_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_reg_wr = 1'b1;
      o_reg_addr = a;
      o_reg_wdata = d;
      @(posedge i_core_clk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_wdata = ~d; // stale data must not be relied on
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_reg_addr = a;
      @(posedge i_core_clk);
      #1;
      d = i_reg_rdata;
   endtask
   // status read clears flags in default and linked chaining
   task automatic ack();
      @(posedge i_core_clk);
      #1;
      o_status_read = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_status_read = 1'b0;
   endtask
endmodule // accel_host_model

/* File: bench/accel_timing_measurement_settings_ctrl_tb_top.sv */
// self-checking bench for the timing and measurement register block
`timescale 1ns/1ps
module accel_timing_measurement_settings_ctrl_tb_top;
   import accel_timing_pkg::*;
   localparam int HZ = 64000; // 1 ms is 64 cycles, every rate divides evenly
   localparam int MSC = HZ / 1000;
   logic i_core_clk = 1'b0, i_reset = 1'b1, i_reg_wr, i_status_read;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv;
   logic mot_en = 1'b1, still_en = 1'b1, mot_ev = 1'b0, still_ev = 1'b0;
   logic wake = 1'b0, oclk = 1'b0, otrig = 1'b0, wsel = 1'b0, pk;
   logic o_sample_tick, o_wake_measurement_settings, o_doze_active, o_motion_armed, o_stillness_armed;
   logic o_motion_flag, o_stillness_flag, o_outside_clock_en, o_outside_trigger_en;
   logic o_low_noise, o_overrange_off, o_rate_code_valid, o_bw_code_valid;
   logic [2:0] o_bandwidth_sel;
   int failures = 0, tests_run = 0, n;
   int rt[5] = '{400, 800, 1600, 3200, 6400};
   logic [2:0] bws[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
   assign pk = wsel ? o_wake_measurement_settings : o_sample_tick;
   always #12.5 i_core_clk = ~i_core_clk;
   accel_host_model host (.i_core_clk(i_core_clk), .i_reg_rdata(o_reg_rdata),
      .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
      .o_status_read(i_status_read));
   accel_timing_measurement_settings_ctrl #(.CLOCK_HZ(HZ)) dut (.i_core_clk(i_core_clk),
      .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_motion_detect_en(mot_en), .i_stillness_detect_en(still_en),
      .i_motion_event(mot_ev), .i_stillness_event(still_ev),
      .i_status_read(i_status_read), .i_wake_mode(wake),
      .i_outside_clock_tick(oclk), .i_outside_trigger(otrig),
      .o_sample_tick(o_sample_tick), .o_wake_measurement_settings(o_wake_measurement_settings),
      .o_doze_active(o_doze_active), .o_motion_armed(o_motion_armed),
      .o_stillness_armed(o_stillness_armed), .o_motion_flag(o_motion_flag),
      .o_stillness_flag(o_stillness_flag), .o_outside_clock_en(o_outside_clock_en),
      .o_outside_trigger_en(o_outside_trigger_en), .o_low_noise(o_low_noise),
      .o_overrange_off(o_overrange_off), .o_bandwidth_sel(o_bandwidth_sel),
      .o_rate_code_valid(o_rate_code_valid), .o_bw_code_valid(o_bw_code_valid));
   task automatic tick();
      @(posedge i_core_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rst();
      i_reset = 1'b1;
      repeat (3) tick();
      i_reset = 1'b0;
   endtask
   // cycles from one pulse of pk to the next, bounded
   task automatic gap(output int c);
      c = 0;
      while (pk !== 1'b1 && c < 20000) begin tick(); c++; end
      c = 0;
      do begin tick(); c++; end while (pk !== 1'b1 && c < 20000);
   endtask
   task automatic pulse(ref logic s);
      tick();
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask
   task automatic t_regs();
      host.rd(TIMING_ADDR, rv); chk(rv, 8'h00);
      chk({o_outside_clock_en, o_outside_trigger_en}, 2'b00);
      host.wr(TIMING_ADDR, 8'hE3);
      host.wr(8'h3f, 8'hFF);
      host.rd(8'h3f, rv); chk(rv, 8'h00);
      host.rd(TIMING_ADDR, rv); chk(rv, 8'hE3);
      chk({o_outside_clock_en, o_outside_trigger_en, o_rate_code_valid}, 3'b110);
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h8A);
      tick();
      chk({o_overrange_off, o_low_noise, o_bandwidth_sel, o_bw_code_valid}, 6'b110100);
      host.rd(MEASUREMENT_SETTINGS_ADDR, rv); chk(rv, 8'h8A);
      foreach (bws[i]) begin
         host.wr(MEASUREMENT_SETTINGS_ADDR, {5'h00, bws[i]});
         tick();
         chk({o_bandwidth_sel, o_bw_code_valid}, {bws[i], 1'b1});
      end
   endtask
   task automatic t_rates();
      for (int c = 0; c < 5; c++) begin
         host.wr(TIMING_ADDR, {c[2:0], 5'h00});
         gap(n); chk(n, HZ / rt[c]);
         chk(o_rate_code_valid, 1'b1);
      end
   endtask
   task automatic t_outside();
      host.wr(TIMING_ADDR, 8'h02);
      pulse(oclk); chk(o_sample_tick, 1'b1);
      n = 0;
      repeat (200) begin tick(); n += o_sample_tick; end
      chk(n, 0);
      host.wr(TIMING_ADDR, 8'h01);
      pulse(otrig); chk(o_sample_tick, 1'b1);
      host.wr(TIMING_ADDR, 8'hA0);
      tick();
      n = 0;
      repeat (200) begin tick(); n += o_sample_tick; end
      chk({n[7:0], o_rate_code_valid}, 9'h000);
   endtask
   task automatic t_doze();
      wake = 1'b1;
      wsel = 1'b1;
      host.wr(TIMING_ADDR, 8'h00);
      gap(n); chk(n, 52 * MSC);
      host.wr(TIMING_ADDR, 8'h04);
      gap(n); chk(n, 104 * MSC);
      wake = 1'b0;
      wsel = 1'b0;
   endtask
   task automatic t_chain();
      rst();
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h50);
      tick();
      chk({o_motion_armed, o_stillness_armed}, 2'b10);
      pulse(mot_ev); chk({o_motion_flag, o_motion_armed, o_stillness_armed}, 3'b101);
      tick(); chk(o_motion_flag, 1'b1);
      host.ack(); tick(); chk(o_motion_flag, 1'b0);
      pulse(still_ev); chk({o_doze_active, o_motion_armed}, 2'b11);
      rst();
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h60);
      pulse(mot_ev); chk(o_motion_flag, 1'b1);
      tick(); chk(o_motion_flag, 1'b0);
      rst();
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h40);
      tick(); chk({o_motion_armed, o_stillness_armed}, 2'b11);
      pulse(still_ev); chk({o_stillness_flag, o_doze_active}, 2'b10);
      still_en = 1'b0;
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h10);
      tick();
      pulse(mot_ev); chk({o_motion_armed, o_stillness_armed}, 2'b10);
      still_en = 1'b1;
      host.wr(MEASUREMENT_SETTINGS_ADDR, 8'h70);
      tick(); chk({o_motion_armed, o_stillness_armed, o_doze_active}, 3'b110);
   endtask
   initial begin
      #(25 * 80000);
      failures++;
      test_done();
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      rst();
      t_regs();
      t_rates();
      t_outside();
      t_doze();
      t_chain();
      test_done();
   end
endmodule // accel_timing_measurement_settings_ctrl_tb_top
